// ### logic/prc_pkg.sv
// Package with register map, field layouts, timing and carrier types of the reset sequencer.
`default_nettype none
package prc_pkg;
   // Configuration space layout.
   localparam logic [7:0]  SYS_CTRL_OFF     = 8'h80;
   localparam logic [7:0]  PM_CTX_OFF       = 8'h84;
   localparam int          KEEP_CLOCK_BIT   = 1;
   localparam logic [31:0] SYS_CTRL_RST     = 32'h0000_0000;
   localparam logic [31:0] PM_CTX_RST       = 32'h0000_0000;
   localparam int          PME_STATUS_BIT   = 0;
   localparam int          PME_ENABLE_BIT   = 1;
   localparam logic [31:0] PM_CTX_MASK      = 32'h0000_0003;
   localparam logic [31:0] DATA_ZERO        = 32'h0000_0000;

   // Clock-run hold time, rounded up to whole bus clock cycles.
   localparam int          CLK_PERIOD_NS    = 50;
   localparam int          KEEP_HOLD_NS     = 100;
   localparam int          KEEP_HOLD_CYC    = (KEEP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CNT_W            = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;
   localparam logic [CNT_W-1:0] KEEP_HOLD   = CNT_W'(KEEP_HOLD_CYC);

   // Clock-run responder states.
   typedef enum logic [1:0] {
      CR_IDLE    = 2'b00,
      CR_ASSERT  = 2'b01,
      CR_RELEASE = 2'b10
   } prc_cr_state_e;

   // One configuration access on the 32-bit multiplexed bus.
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } prc_cfg_req_s;

   // Answer to a configuration access.
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } prc_cfg_rsp_s;
endpackage
`default_nettype wire

// ### logic/prc_rst_sync.sv
// Reset synchroniser: asynchronous assertion, release on the bus clock.
`timescale 1ns/1ps
`default_nettype none
module prc_rst_sync
   import prc_pkg::*;
(
   input  wire logic clk,
   input  wire logic arst_n,
   output logic      srst_n
);
   logic stage1_q;
   logic stage2_q;

   // Two flops hold reset low until two edges after the source is released.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1_q <= 1'b0;
         stage2_q <= 1'b0;
      end else begin
         stage1_q <= 1'b1;
         stage2_q <= stage1_q;
      end
   end

   assign srst_n = stage2_q;
endmodule // prc_rst_sync
`default_nettype wire

// ### logic/prc_top.sv
// Reset and clock-run sequencer of the primary bus port, with its configuration registers.
//
// Overview of operation
// R1 - Answer clock-run stop requests when clock needed.
// R2 - Keep-clock bit 1 at 80h, reset enables; the code resets it to 0, keep clock off.
// R3 - Sample all bus inputs on clock rising edge.
// R4 - Bus reset floats outputs, clears registers.
// R5 - Suspend: bus reset floats, keeps registers.
// R6 - Global reset floats and defaults everything.
// R7 - Host asserts global reset only at boot.
// R8 - Bus reset keeps wake context across D3.
// R9 - Bus carries 32-bit multiplexed address and data.
// R10 - Resets assert asynchronously, release on clock.
`timescale 1ns/1ps
`default_nettype none
module prc_top
   import prc_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   input  wire logic         bus_reset_in_n,
   input  wire logic         suspend_n,
   input  wire logic         clock_run_request_in,
   output logic              clock_run_request_out,
   output logic              clock_run_request_oe,
   input  wire logic         clock_needed,
   input  wire logic         wake_event,
   input  wire prc_cfg_req_s cfg_req,
   output prc_cfg_rsp_s      cfg_rsp,
   output logic              outputs_float,
   output logic              keep_clock,
   output logic              pme_request
);
   // Reset fabric.
   logic glob_rst_n;
   logic bus_rst_n;
   logic reg_rst_n;
   logic bus_src_n;
   logic reg_src_n;

   // Bus reset always halts the function; it reaches the registers only when
   // suspend protection is off.
   assign bus_src_n = rst_n & bus_reset_in_n;                      // [R4] [R5]
   assign reg_src_n = rst_n & (bus_reset_in_n | ~suspend_n);       // [R5] [R6]

   // Every reset asserts at once and releases two edges later.
   prc_rst_sync u_glob_sync (
      .clk    (clk),
      .arst_n (rst_n),
      .srst_n (glob_rst_n)
   ); // [R10] [R6]

   prc_rst_sync u_bus_sync (
      .clk    (clk),
      .arst_n (bus_src_n),
      .srst_n (bus_rst_n)
   ); // [R10] [R4]

   prc_rst_sync u_reg_sync (
      .clk    (clk),
      .arst_n (reg_src_n),
      .srst_n (reg_rst_n)
   ); // [R10] [R5]

   // Outputs float while any reset holds the function off.
   assign outputs_float = ~bus_rst_n;                               // [R4] [R5] [R6]

   // Clock-run pin synchroniser; only the second flop is read. It resets to the
   // running level, low, so that no stop request is seen just after reset.
   logic cr_meta_q;
   logic cr_sync_q;

   always_ff @(posedge clk or negedge bus_rst_n) begin
      if (!bus_rst_n) begin
         cr_meta_q <= 1'b0;
         cr_sync_q <= 1'b0;
      end else if (clk_en) begin
         cr_meta_q <= clock_run_request_in;                         // [R3]
         cr_sync_q <= cr_meta_q;
      end
   end

   // Configuration registers.
   logic [31:0]   sys_ctrl_q;
   logic [31:0]   sys_ctrl_d;
   logic [31:0]   pm_ctx_q;
   logic [31:0]   pm_ctx_d;
   prc_cfg_rsp_s  rsp_q;
   prc_cfg_rsp_s  rsp_d;

   // Byte-lane merge of a write into a register image.
   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // System control: whole word is storage, cleared by global reset or by an
   // unprotected bus reset.
   always_comb begin
      sys_ctrl_d = sys_ctrl_q;
      if (cfg_req.wr && (cfg_req.addr == SYS_CTRL_OFF)) begin
         sys_ctrl_d = merge_be(sys_ctrl_q, cfg_req.wdata, cfg_req.be); // [R2] [R9]
      end
   end

   always_ff @(posedge clk or negedge reg_rst_n) begin
      if (!reg_rst_n) begin
         sys_ctrl_q <= SYS_CTRL_RST;                                // [R2] [R4]
      end else if (clk_en && bus_rst_n) begin
         sys_ctrl_q <= sys_ctrl_d;
      end
   end

   // Wake context: status is set by wake events and cleared by writing one;
   // a wake event in the clearing cycle wins. Only global reset clears it.
   always_comb begin
      logic [31:0] wr_v;
      wr_v     = DATA_ZERO;
      pm_ctx_d = pm_ctx_q;
      if (cfg_req.wr && (cfg_req.addr == PM_CTX_OFF) && bus_rst_n) begin
         wr_v = merge_be(DATA_ZERO, cfg_req.wdata, cfg_req.be);
         pm_ctx_d[PME_ENABLE_BIT] = wr_v[PME_ENABLE_BIT] |
                                    (~cfg_req.be[0] & pm_ctx_q[PME_ENABLE_BIT]);
         if (wr_v[PME_STATUS_BIT]) begin
            pm_ctx_d[PME_STATUS_BIT] = 1'b0;
         end
      end
      if (wake_event) begin
         pm_ctx_d[PME_STATUS_BIT] = 1'b1;
      end
      pm_ctx_d = pm_ctx_d & PM_CTX_MASK;
   end

   always_ff @(posedge clk or negedge glob_rst_n) begin
      if (!glob_rst_n) begin
         pm_ctx_q <= PM_CTX_RST;                                    // [R6]
      end else if (clk_en) begin
         pm_ctx_q <= pm_ctx_d;                                      // [R8]
      end
   end

   // Read answer: one cycle after the request, unmapped offsets read zero.
   always_comb begin
      rsp_d.ack   = 1'b0;
      rsp_d.rdata = rsp_q.rdata;
      if (cfg_req.rd || cfg_req.wr) begin
         rsp_d.ack = 1'b1;
      end
      if (cfg_req.rd) begin
         if (cfg_req.addr == SYS_CTRL_OFF) begin
            rsp_d.rdata = sys_ctrl_q;                               // [R9]
         end else if (cfg_req.addr == PM_CTX_OFF) begin
            rsp_d.rdata = pm_ctx_q;
         end else begin
            rsp_d.rdata = DATA_ZERO;
         end
      end
   end

   always_ff @(posedge clk or negedge bus_rst_n) begin
      if (!bus_rst_n) begin
         rsp_q <= '0;                                               // [R4]
      end else if (clk_en) begin
         rsp_q <= rsp_d;
      end
   end

   assign cfg_rsp     = rsp_q;
   assign keep_clock  = sys_ctrl_q[KEEP_CLOCK_BIT];
   assign pme_request = pm_ctx_q[PME_STATUS_BIT] & pm_ctx_q[PME_ENABLE_BIT] & bus_rst_n;

   // Clock-run responder. The line is active low: the central resource lets it
   // go high to ask for a stop; if the clock is still wanted, the device pulls
   // it low for the hold time and then releases it.
   prc_cr_state_e    cr_state_q;
   prc_cr_state_e    cr_state_d;
   logic [CNT_W-1:0] cr_cnt_q;
   logic [CNT_W-1:0] cr_cnt_d;
   logic             want_clock;

   assign want_clock = clock_needed | keep_clock;                   // [R1] [R2]

   always_comb begin
      cr_state_d = cr_state_q;
      cr_cnt_d   = cr_cnt_q;
      case (cr_state_q)
         CR_IDLE: begin
            if (cr_sync_q && want_clock) begin
               cr_state_d = CR_ASSERT;                              // [R1]
               cr_cnt_d   = KEEP_HOLD;
            end
         end
         CR_ASSERT: begin
            if (cr_cnt_q == CNT_ONE) begin
               cr_state_d = CR_RELEASE;
               cr_cnt_d   = CNT_ZERO;
            end else begin
               cr_cnt_d = cr_cnt_q - CNT_ONE;
            end
         end
         CR_RELEASE: begin
            // Wait until the sampled line shows our low before looking again.
            if (!cr_sync_q) begin
               cr_state_d = CR_IDLE;
            end
         end
         default: begin
            cr_state_d = CR_IDLE;
            cr_cnt_d   = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk or negedge bus_rst_n) begin
      if (!bus_rst_n) begin
         cr_state_q <= CR_IDLE;                                     // [R4]
         cr_cnt_q   <= CNT_ZERO;
      end else if (clk_en) begin
         cr_state_q <= cr_state_d;
         cr_cnt_q   <= cr_cnt_d;
      end
   end

   // Open-drain drive: only ever low, never while floating.
   assign clock_run_request_out = 1'b0;
   assign clock_run_request_oe  = (cr_state_q == CR_ASSERT) & bus_rst_n; // [R1] [R4]
endmodule // prc_top
`default_nettype wire

// ### tb/prc_host_model.sv
// Central resource model driving the pulled-up clock-run wire.
`timescale 1ns/1ps
`default_nettype none
module prc_host_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic stop_req,
   input  wire logic dev_oe,
   output logic      line
);
   logic seen_q;
   logic seen_d;
   // Host releases the wire to ask for a stop and re-drives it once the device objects.
   always_comb seen_d = stop_req & (seen_q | dev_oe);
   // Remembers that the device objected, until the stop request is withdrawn.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_q <= 1'b0;
      end else begin
         seen_q <= seen_d;
      end
   end
   assign line = ~(dev_oe | ~stop_req | seen_q);
endmodule // prc_host_model
`default_nettype wire

// ### tb/prc_monitor.sv
// Checker of the sequencer's port behaviour.
`timescale 1ns/1ps
`default_nettype none
module prc_monitor
   import prc_pkg::*;
(
   input wire logic         clk,
   input wire logic         rst_n,
   input wire logic         clk_en,
   input wire logic         bus_reset_in_n,
   input wire logic         suspend_n,
   input wire logic         clock_run_request_out,
   input wire logic         clock_run_request_oe,
   input wire logic         clock_needed,
   input wire prc_cfg_req_s cfg_req,
   input wire prc_cfg_rsp_s cfg_rsp,
   input wire logic         outputs_float,
   input wire logic         keep_clock,
   input wire logic         pme_request
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_answer: assert property (clk_en && (cfg_req.rd || cfg_req.wr)
      && !outputs_float |=> cfg_rsp.ack) else $error("missing ack");
   a_ack_cause: assert property (cfg_rsp.ack |-> $past(cfg_req.rd) || $past(cfg_req.wr))
      else $error("stray ack");
   a_float_quiet: assert property (outputs_float |-> !clock_run_request_oe
      && !cfg_rsp.ack) else $error("active while floating");
   a_bus_float: assert property (!bus_reset_in_n |-> outputs_float && !pme_request)
      else $error("bus reset not floating");
   a_float_release: assert property ($rose(bus_reset_in_n) |-> ##[1:3] !outputs_float)
      else $error("float not released");
   a_suspend_keep: assert property (!bus_reset_in_n && !suspend_n |-> $stable(keep_clock))
      else $error("suspend lost register");
   a_oe_width: assert property ($rose(clock_run_request_oe)
      |-> clock_run_request_oe[*2] ##1 !clock_run_request_oe) else $error("oe width");
   a_od_low: assert property (clock_run_request_out == 1'b0)
      else $error("drive level");
   a_oe_cause: assert property ($rose(clock_run_request_oe)
      |-> $past(clock_needed || keep_clock)) else $error("oe without need");
   a_keep_write: assert property (clk_en && cfg_req.wr && cfg_req.be[0] && !outputs_float
      && cfg_req.addr == SYS_CTRL_OFF |=> keep_clock == $past(cfg_req.wdata[1]))
      else $error("keep bit");
   cover property ($rose(clock_run_request_oe));
   cover property (!bus_reset_in_n && !suspend_n);
   cover property (pme_request);
endmodule // prc_monitor
bind prc_top prc_monitor i_prc_monitor (.clk, .rst_n, .clk_en, .bus_reset_in_n, .suspend_n,
   .clock_run_request_out, .clock_run_request_oe, .clock_needed, .cfg_req, .cfg_rsp,
   .outputs_float, .keep_clock, .pme_request);
`default_nettype wire

// ### tb/prc_top_tb.sv
// Self-checking bench of the reset and clock-run sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("wrong value at %0t: %h not %h", $time, a, b); end end
module prc_top_tb
   import prc_pkg::*;
;
   logic         clk = 0, rst_n = 0, bus_n = 1, susp_n = 1, stop = 0, need = 0, wake = 0;
   logic         ce = 1;
   logic         line, oe, od, flt, kc, pme;
   logic [3:0]   hi, b;
   logic [31:0]  sc, v;
   logic [32:0]  e;
   logic [32:0]  expq[$];
   prc_cfg_req_s req = '0;
   prc_cfg_rsp_s rsp;
   int           n_fail = 0, total_checks = 0, seed = 8919;
   always #25 clk = ~clk;
   prc_host_model i_prc_host_model (.clk, .rst_n, .stop_req(stop), .dev_oe(oe), .line);
   prc_top i_prc_top (.clk, .rst_n, .clk_en(ce), .bus_reset_in_n(bus_n), .suspend_n(susp_n),
      .clock_run_request_in(line), .clock_run_request_out(od), .clock_run_request_oe(oe),
      .clock_needed(need), .wake_event(wake), .cfg_req(req), .cfg_rsp(rsp),
      .outputs_float(flt), .keep_clock(kc), .pme_request(pme));
   // One access; the expected answer is queued for the watcher.
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, input logic [31:0] x);
      @(posedge clk);
      req <= '{rd: ~w, wr: w, addr: a, be: be, wdata: d};
      expq.push_back({~w, x});
      @(posedge clk);
      req <= '0;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic drain;
      for (int k = 0; k < 20 && expq.size() > 0; k++) @(posedge clk);
      if (expq.size() > 0) begin
         n_fail++;
         $display("wrong value at %0t: answer missing", $time);
         end_sim;
      end
   endtask
   // Stop request from the host; counts the cycles the device holds the wire.
   task automatic crun(input logic [3:0] x);
      hi = 0;
      @(posedge clk);
      stop <= 1;
      repeat (12) begin @(posedge clk); hi = hi + oe; end
      stop <= 0;
      repeat (4) @(posedge clk);
      `CHK(hi, x)
      `CHK(od, 1'b0)
   endtask
   task automatic bus_rst;
      @(posedge clk);
      bus_n <= 0;
      repeat (2) @(posedge clk);
      `CHK({flt, pme}, 2'b10)
      bus_n <= 1;
      repeat (3) @(posedge clk);
   endtask
   // Watcher: every ack takes the oldest note; reads compare their data.
   always @(posedge clk) if (rsp.ack === 1'b1) begin
      if (expq.size() == 0) begin n_fail++; $display("wrong value at %0t: stray ack", $time); end
      else begin e = expq.pop_front(); if (e[32]) `CHK(rsp.rdata, e[31:0]) end
   end
   // Main sequence.
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1; // Global reset at boot; the wake test later uses bus reset only.
      repeat (3) @(posedge clk);
      `CHK({kc, flt}, 2'b00)
      sc = SYS_CTRL_RST;
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         b = $random(seed);
         acc(1, SYS_CTRL_OFF, v, b, 0);
         for (int j = 0; j < 4; j++) if (b[j]) sc[8*j +: 8] = v[8*j +: 8];
         acc(0, SYS_CTRL_OFF, 0, 4'hf, sc);
      end
      acc(1, 8'h88, '1, 4'hf, 0);
      acc(0, 8'h88, 0, 4'hf, DATA_ZERO);
      $display("registers done");
      acc(1, SYS_CTRL_OFF, 0, 4'hf, 0);
      repeat (3) @(posedge clk);
      crun(0);
      need <= 1;
      crun(2);
      need <= 0;
      acc(1, SYS_CTRL_OFF, 32'h2, 4'hf, 0);
      crun(2);
      $display("clock run done");
      acc(1, PM_CTX_OFF, 32'h2, 4'hf, 0);
      @(posedge clk);
      wake <= 1;
      @(posedge clk);
      wake <= 0;
      repeat (2) @(posedge clk);
      `CHK(pme, 1'b1)
      drain;
      bus_rst;
      acc(0, SYS_CTRL_OFF, 0, 4'hf, SYS_CTRL_RST);
      acc(0, PM_CTX_OFF, 0, 4'hf, 32'h3);
      v = $random(seed);
      acc(1, SYS_CTRL_OFF, v, 4'hf, 0);
      susp_n <= 0;
      bus_rst;
      susp_n <= 1;
      acc(0, SYS_CTRL_OFF, 0, 4'hf, v);
      drain;
      $display("bus reset done");
      rst_n <= 0;
      repeat (2) @(posedge clk);
      `CHK({flt, kc}, 2'b10)
      rst_n <= 1;
      repeat (3) @(posedge clk);
      acc(0, SYS_CTRL_OFF, 0, 4'hf, SYS_CTRL_RST);
      acc(0, PM_CTX_OFF, 0, 4'hf, PM_CTX_RST);
      // A write while the clock enable is low must not land.
      @(posedge clk);
      ce  <= 0;
      req <= '{rd: 1'b0, wr: 1'b1, addr: SYS_CTRL_OFF, be: 4'hf, wdata: 32'h2};
      @(posedge clk);
      req <= '0;
      repeat (2) @(posedge clk);
      `CHK(kc, 1'b0)
      ce <= 1;
      acc(0, SYS_CTRL_OFF, 0, 4'hf, SYS_CTRL_RST);
      drain;
      $display("global reset done");
      end_sim;
   end
endmodule // prc_top_tb
`default_nettype wire
